/* logic/synth_pkg.sv */
// constants, types and register map of the synthesizer channel block
// assumes a 32-bit apb slave and one clock domain
package synth_pkg;

    // ------------------------------------------------------------------
    // register map, byte addresses of aligned words
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] OFF_BASE = 8'h00;
    localparam logic [7:0] OFF_CTRL = 8'h04;
    localparam logic [7:0] OFF_CHAN = 8'h08;
    localparam logic [7:0] OFF_SPACE = 8'h0C;
    localparam logic [7:0] OFF_CAL_TX = 8'h10;
    localparam logic [7:0] OFF_CAL_RX = 8'h14;
    localparam logic [7:0] OFF_STATUS = 8'h18;
    localparam logic [7:0] OFF_FREQ = 8'h1C;

    // ------------------------------------------------------------------
    // field widths and positions
    // ------------------------------------------------------------------
    localparam int unsigned BASE_W = 28;
    localparam int unsigned CHAN_W = 8;
    localparam int unsigned SPACE_W = 8;
    localparam int unsigned CAL_W = 7;
    localparam int unsigned CP_W = 3;
    localparam int unsigned FREQ_W = 31;
    localparam int unsigned CTRL_BAND_BIT = 0;
    localparam int unsigned CTRL_REFH_BIT = 1;
    localparam int unsigned CTRL_CP_LSB = 2;
    localparam int unsigned CTRL_SPLIT_BIT = 5;
    localparam int unsigned CTRL_CALDIS_BIT = 6;
    localparam int unsigned STAT_STATE_LSB = 0;
    localparam int unsigned STAT_DBL_BIT = 2;
    localparam int unsigned STAT_TX_BIT = 3;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [BASE_W-1:0] RST_BASE = 28'h0000000;
    localparam logic [CHAN_W-1:0] RST_CHAN = 8'h00;
    localparam logic [SPACE_W-1:0] RST_SPACE = 8'h00;
    localparam logic [CAL_W-1:0] RST_CAL = 7'h00;
    localparam logic [CP_W-1:0] RST_CP = 3'h0;

    // ------------------------------------------------------------------
    // frequency arithmetic: result in units of f_ref / 2^23
    // ------------------------------------------------------------------
    localparam int unsigned OUT_FRAC_BITS = 23;
    localparam int unsigned CH_FRAC_BITS = 15;
    localparam int unsigned CHAN_SHIFT = OUT_FRAC_BITS - CH_FRAC_BITS;
    localparam logic [1:0] BASE_SHIFT_TOP = 2'h2;
    localparam logic [3:0] BAND_DIV_HIGH = 4'h4;
    localparam logic [3:0] BAND_DIV_MID = 4'h8;
    localparam logic [1:0] REF_DIV_OFF = 2'h1;
    localparam logic [1:0] REF_DIV_ON = 2'h2;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        RADIO_OTHER, RADIO_READY, RADIO_LOCK, RADIO_RX, RADIO_TX
    } radio_state_t;

    typedef enum logic [1:0] {SYN_IDLE, SYN_CAL, SYN_RUN} synth_state_t;

    typedef struct packed {
        logic [BASE_W-1:0] synth_base_word;
        logic [CHAN_W-1:0] channel_index;
        logic [SPACE_W-1:0] channel_spacing_factor;
        logic band_divider_select;
        logic reference_halving_enable;
    } synth_cfg_t;

    typedef struct packed {
        logic [FREQ_W-1:0] freq_word;
        logic [3:0] band_div_ratio;
        logic [1:0] ref_div_ratio;
        logic [CP_W-1:0] charge_pump_current_select;
        logic detector_split_enable;
        logic [CAL_W-1:0] vco_cal_word;
        logic cal_start;
        logic synth_enable;
    } pll_drive_t;

endpackage

/* logic/synth_freq_calc.sv */
// combinational target-word arithmetic for the synthesizer
// assumes the caller registers the result
`timescale 1ns/10ps
module synth_freq_calc (
    input wire synth_pkg::synth_cfg_t cfg,
    output logic [synth_pkg::FREQ_W-1:0] freq_word,
    output logic [3:0] band_div_ratio,
    output logic [1:0] ref_div_ratio
);

    // ------------------------------------------------------------------
    // base plus channel offset
    // ------------------------------------------------------------------
    logic [1:0] base_shift;
    logic [synth_pkg::FREQ_W-1:0] base_ext;
    logic [synth_pkg::FREQ_W-1:0] chan_ext;
    logic [synth_pkg::CHAN_W+synth_pkg::SPACE_W-1:0] chan_prod;

    // base scaled by 8/(b/2*d): shift of 2, 1 or 0 keeps it exact
    always_comb begin
        base_shift = synth_pkg::BASE_SHIFT_TOP
                     - {1'b0, cfg.band_divider_select}
                     - {1'b0, cfg.reference_halving_enable};
        base_ext = synth_pkg::FREQ_W'(cfg.synth_base_word);
        chan_prod = cfg.channel_index * cfg.channel_spacing_factor;
        chan_ext = synth_pkg::FREQ_W'(chan_prod);
        freq_word = (base_ext << base_shift)
                    + (chan_ext << synth_pkg::CHAN_SHIFT);
        band_div_ratio = cfg.band_divider_select ? synth_pkg::BAND_DIV_MID
                         : synth_pkg::BAND_DIV_HIGH;
        ref_div_ratio = cfg.reference_halving_enable ? synth_pkg::REF_DIV_ON
                        : synth_pkg::REF_DIV_OFF;
    end

endmodule

/* logic/synth_cal_fsm.sv */
// lock sequencer: optional vco calibration before running
// assumes tick marks the digital-clock cycles and cal done is a level
`timescale 1ns/10ps
module synth_cal_fsm (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tick,
    input wire logic lock_req,
    input wire logic release_req,
    input wire logic cal_disable,
    input wire logic vco_cal_done,
    output synth_pkg::synth_state_t state_q,
    output logic load,
    output logic capture
);

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    synth_pkg::synth_state_t state_d;

    // requests during calibration are ignored so the sweep is not torn
    always_comb begin
        state_d = state_q;
        load = 1'b0;
        capture = 1'b0;
        if (tick) begin
            unique case (state_q)
                synth_pkg::SYN_IDLE, synth_pkg::SYN_RUN: begin
                    if (lock_req) begin
                        load = 1'b1;
                        state_d = cal_disable ? synth_pkg::SYN_RUN
                                  : synth_pkg::SYN_CAL;
                    end else if (release_req) begin
                        state_d = synth_pkg::SYN_IDLE;
                    end
                end
                synth_pkg::SYN_CAL: begin
                    if (vco_cal_done) begin
                        capture = 1'b1;
                        state_d = synth_pkg::SYN_RUN;
                    end
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= synth_pkg::SYN_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    a_cal_starts: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && lock_req && !cal_disable && state_q != synth_pkg::SYN_CAL)
        |=> state_q == synth_pkg::SYN_CAL)
        else $error("calibration did not start on lock request");

    a_cal_skipped: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && lock_req && cal_disable && state_q != synth_pkg::SYN_CAL)
        |=> state_q == synth_pkg::SYN_RUN)
        else $error("disabled calibration still ran");

    a_cal_ends: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && state_q == synth_pkg::SYN_CAL && vco_cal_done)
        |-> capture ##1 state_q == synth_pkg::SYN_RUN)
        else $error("calibration end not captured");

endmodule

/* logic/synth_channel_config.sv */
// apb register file and lock control of the fractional synthesizer
// assumes apb master in the pclk domain and an analog pll that holds
// vco_cal_done high until cal_start falls
//
// Contract
// - doubled reference runs logic at half rate
// - calibrate on every lock request taken in idle or run unless disabled; requests during calibration are ignored
// - calibration result written back and driven
// - centre is base plus channel times spacing step
// - base from 28-bit word, band and reference dividers
// - band select chooses divide by 4 or 8
// - reference halving chooses division by 1 or 2
// - channel index is one 8-bit register
`timescale 1ns/10ps
module synth_channel_config (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [synth_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ref_doubled,
    input wire synth_pkg::radio_state_t radio_state,
    input wire logic vco_cal_done,
    input wire logic [synth_pkg::CAL_W-1:0] vco_cal_result,
    output synth_pkg::pll_drive_t pll_drive,
    output logic dig_tick
);

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic [synth_pkg::BASE_W-1:0] base_q, base_d;
    logic [synth_pkg::CHAN_W-1:0] chan_q, chan_d;
    logic [synth_pkg::SPACE_W-1:0] space_q, space_d;
    logic [synth_pkg::CAL_W-1:0] cal_tx_q, cal_tx_d, cal_rx_q, cal_rx_d;
    logic [synth_pkg::CP_W-1:0] cp_q, cp_d;
    logic band_q, band_d, refh_q, refh_d, split_q, split_d;
    logic caldis_q, caldis_d;
    logic ref_dbl_q, ref_dbl_d, strap_done_q, strap_done_d;
    logic phase_q, phase_d, tx_q, tx_d;
    synth_pkg::radio_state_t prev_q, prev_d;
    synth_pkg::synth_cfg_t cfg_q, cfg_d, live_cfg;
    synth_pkg::pll_drive_t drive_d;
    synth_pkg::synth_state_t state_q;
    logic [31:0] prdata_d;
    logic pready_d, pslverr_d, dig_tick_d;
    logic tick, apb_wr, apb_setup, mapped, lock_req, release_req;
    logic in_lock, was_lock, load, capture;
    logic [synth_pkg::FREQ_W-1:0] freq_word;
    logic [3:0] band_ratio;
    logic [1:0] ref_ratio;

    // ------------------------------------------------------------------
    // digital clock rate
    // ------------------------------------------------------------------

    // strap caught on the first enabled cycle after reset release
    always_comb begin
        strap_done_d = strap_done_q | ce;
        ref_dbl_d = strap_done_q ? ref_dbl_q : (ce ? ref_doubled : ref_dbl_q);
        phase_d = (ce && strap_done_q && ref_dbl_q) ? ~phase_q : phase_q;
        tick = ce & strap_done_q & (~ref_dbl_q | phase_q);
        dig_tick_d = ce ? tick : dig_tick; // frozen with the rest
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_done_q <= 1'b0;
            ref_dbl_q <= 1'b0;
            phase_q <= 1'b0;
        end else begin
            strap_done_q <= strap_done_d;
            ref_dbl_q <= ref_dbl_d;
            phase_q <= phase_d;
        end
    end

    // ------------------------------------------------------------------
    // apb slave and register file
    // ------------------------------------------------------------------
    always_comb begin
        apb_setup = ce & psel & ~penable & ~pready;
        apb_wr = ce & psel & penable & pready & pwrite;
        mapped = 1'b1;
        prdata_d = prdata;
        unique case (paddr)
            synth_pkg::OFF_BASE: prdata_d = 32'(base_q);
            synth_pkg::OFF_CTRL: begin
                prdata_d = 32'h00000000;
                prdata_d[synth_pkg::CTRL_BAND_BIT] = band_q;
                prdata_d[synth_pkg::CTRL_REFH_BIT] = refh_q;
                prdata_d[synth_pkg::CTRL_CP_LSB +: synth_pkg::CP_W] = cp_q;
                prdata_d[synth_pkg::CTRL_SPLIT_BIT] = split_q;
                prdata_d[synth_pkg::CTRL_CALDIS_BIT] = caldis_q;
            end
            synth_pkg::OFF_CHAN: prdata_d = 32'(chan_q);
            synth_pkg::OFF_SPACE: prdata_d = 32'(space_q);
            synth_pkg::OFF_CAL_TX: prdata_d = 32'(cal_tx_q);
            synth_pkg::OFF_CAL_RX: prdata_d = 32'(cal_rx_q);
            synth_pkg::OFF_STATUS: begin
                prdata_d = 32'h00000000;
                prdata_d[synth_pkg::STAT_STATE_LSB +: 2] = state_q;
                prdata_d[synth_pkg::STAT_DBL_BIT] = ref_dbl_q;
                prdata_d[synth_pkg::STAT_TX_BIT] = tx_q;
            end
            synth_pkg::OFF_FREQ: prdata_d = 32'(pll_drive.freq_word);
            default: begin
                prdata_d = 32'h00000000;
                mapped = 1'b0;
            end
        endcase
        if (!apb_setup) begin
            prdata_d = prdata;
            mapped = ~pslverr;
        end
        // one wait-free answer: ready rises in the access cycle
        pready_d = ce ? apb_setup : pready;
        pslverr_d = ce ? (apb_setup & ~mapped) : pslverr;
    end

    // software writes; a finishing calibration beats a same-cycle write
    always_comb begin
        base_d = base_q;
        chan_d = chan_q;
        space_d = space_q;
        cp_d = cp_q;
        band_d = band_q;
        refh_d = refh_q;
        split_d = split_q;
        caldis_d = caldis_q;
        cal_tx_d = cal_tx_q;
        cal_rx_d = cal_rx_q;
        if (apb_wr) begin
            unique case (paddr)
                synth_pkg::OFF_BASE: base_d = pwdata[synth_pkg::BASE_W-1:0];
                synth_pkg::OFF_CTRL: begin
                    band_d = pwdata[synth_pkg::CTRL_BAND_BIT];
                    refh_d = pwdata[synth_pkg::CTRL_REFH_BIT];
                    cp_d = pwdata[synth_pkg::CTRL_CP_LSB +: synth_pkg::CP_W];
                    split_d = pwdata[synth_pkg::CTRL_SPLIT_BIT];
                    caldis_d = pwdata[synth_pkg::CTRL_CALDIS_BIT];
                end
                synth_pkg::OFF_CHAN: chan_d = pwdata[synth_pkg::CHAN_W-1:0];
                synth_pkg::OFF_SPACE: space_d = pwdata[synth_pkg::SPACE_W-1:0];
                synth_pkg::OFF_CAL_TX: cal_tx_d = pwdata[synth_pkg::CAL_W-1:0];
                synth_pkg::OFF_CAL_RX: cal_rx_d = pwdata[synth_pkg::CAL_W-1:0];
                default: ;
            endcase
        end
        if (capture) begin
            if (tx_q) begin
                cal_tx_d = vco_cal_result;
            end else begin
                cal_rx_d = vco_cal_result;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_q <= synth_pkg::RST_BASE;
            chan_q <= synth_pkg::RST_CHAN;
            space_q <= synth_pkg::RST_SPACE;
            cp_q <= synth_pkg::RST_CP;
            band_q <= 1'b0;
            refh_q <= 1'b0;
            split_q <= 1'b0;
            caldis_q <= 1'b0;
            cal_tx_q <= synth_pkg::RST_CAL;
            cal_rx_q <= synth_pkg::RST_CAL;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            base_q <= base_d;
            chan_q <= chan_d;
            space_q <= space_d;
            cp_q <= cp_d;
            band_q <= band_d;
            refh_q <= refh_d;
            split_q <= split_d;
            caldis_q <= caldis_d;
            cal_tx_q <= cal_tx_d;
            cal_rx_q <= cal_rx_d;
            prdata <= prdata_d;
            pready <= pready_d;
            pslverr <= pslverr_d;
        end
    end

    // ------------------------------------------------------------------
    // lock requests and latched configuration
    // ------------------------------------------------------------------

    // radio state sampled only on digital-clock cycles
    always_comb begin
        in_lock = (radio_state == synth_pkg::RADIO_LOCK)
                  | (radio_state == synth_pkg::RADIO_RX)
                  | (radio_state == synth_pkg::RADIO_TX);
        was_lock = (prev_q == synth_pkg::RADIO_RX)
                   | (prev_q == synth_pkg::RADIO_TX);
        lock_req = ((prev_q == synth_pkg::RADIO_READY) & in_lock)
                   | (was_lock & (radio_state != prev_q)
                      & ((radio_state == synth_pkg::RADIO_RX)
                         | (radio_state == synth_pkg::RADIO_TX)));
        release_req = ~in_lock;
        prev_d = tick ? radio_state : prev_q;
        live_cfg = '{synth_base_word: base_q, channel_index: chan_q,
                     channel_spacing_factor: space_q,
                     band_divider_select: band_q,
                     reference_halving_enable: refh_q};
        // a running lock keeps the old values until the next request
        cfg_d = load ? live_cfg : cfg_q;
        tx_d = load ? (radio_state == synth_pkg::RADIO_TX) : tx_q;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_q <= synth_pkg::RADIO_OTHER;
            cfg_q <= '0;
            tx_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
            cfg_q <= cfg_d;
            tx_q <= tx_d;
        end
    end

    synth_cal_fsm u_fsm (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick),
        .lock_req(lock_req),
        .release_req(release_req),
        .cal_disable(caldis_q),
        .vco_cal_done(vco_cal_done),
        .state_q(state_q),
        .load(load),
        .capture(capture)
    );

    synth_freq_calc u_calc (
        .cfg(cfg_q),
        .freq_word(freq_word),
        .band_div_ratio(band_ratio),
        .ref_div_ratio(ref_ratio)
    );

    // ------------------------------------------------------------------
    // drive to the analog pll
    // ------------------------------------------------------------------

    // stored word is used as-is when calibration is switched off
    always_comb begin
        drive_d = pll_drive;
        if (ce) begin
            drive_d.freq_word = freq_word;
            drive_d.band_div_ratio = band_ratio;
            drive_d.ref_div_ratio = ref_ratio;
            drive_d.charge_pump_current_select = cp_q;
            drive_d.detector_split_enable = split_q;
            drive_d.vco_cal_word = tx_q ? cal_tx_q : cal_rx_q;
            drive_d.cal_start = (state_q == synth_pkg::SYN_CAL);
            drive_d.synth_enable = (state_q != synth_pkg::SYN_IDLE);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_drive <= '0;
            dig_tick <= 1'b0;
        end else begin
            pll_drive <= drive_d;
            dig_tick <= dig_tick_d;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_tick_halves: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && ref_dbl_q) |=> !tick)
        else $error("doubled reference ticked twice in a row");

    a_tick_full: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && strap_done_q && !ref_dbl_q) |-> tick)
        else $error("plain reference skipped a tick");

    a_cal_writeback: assert property (@(posedge pclk) disable iff (!presetn)
        (capture && !tx_q) |=> cal_rx_q == $past(vco_cal_result))
        else $error("receive calibration word not stored");

    a_chan_write: assert property (@(posedge pclk) disable iff (!presetn)
        (apb_wr && paddr == synth_pkg::OFF_CHAN)
        |=> chan_q == $past(pwdata[7:0]))
        else $error("channel write lost");

    a_freq_sum: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && cfg_q.band_divider_select && cfg_q.reference_halving_enable)
        |=> pll_drive.freq_word == 31'(32'($past(cfg_q.synth_base_word))
            + 32'($past(cfg_q.channel_index))
            * 32'($past(cfg_q.channel_spacing_factor)) * 32'd256))
        else $error("channel offset wrong");

    a_base_scale: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && !cfg_q.band_divider_select
         && !cfg_q.reference_halving_enable)
        |=> pll_drive.freq_word
            == 31'(32'($past(cfg_q.synth_base_word)) * 32'd4
            + 32'($past(cfg_q.channel_index))
            * 32'($past(cfg_q.channel_spacing_factor)) * 32'd256))
        else $error("base word scaling wrong");

    a_band_ratio: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && strap_done_q) |=> pll_drive.band_div_ratio
               == ($past(cfg_q.band_divider_select) ? 4'h8 : 4'h4))
        else $error("band divider ratio wrong");

    a_ref_ratio: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && strap_done_q) |=> pll_drive.ref_div_ratio
               == ($past(cfg_q.reference_halving_enable) ? 2'h2 : 2'h1))
        else $error("reference divider ratio wrong");

    a_latch_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == synth_pkg::SYN_CAL) |=> $stable(cfg_q))
        else $error("settings changed during calibration");

endmodule

/* tb/pll_model.sv */
// analog pll and vco seen from the digital side: calibration handshake
// assumes pll_drive updates on pclk edges and slow picks a long settle
`timescale 1ns/10ps
module pll_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire synth_pkg::pll_drive_t pll_drive,
    input wire logic slow,
    input wire logic [synth_pkg::CAL_W-1:0] cal_value,
    output logic vco_cal_done,
    output logic [synth_pkg::CAL_W-1:0] vco_cal_result
);
    logic [3:0] cnt_q;
    // done stays high until cal_start falls; released result keeps toggling
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 4'h0;
            vco_cal_done <= 1'b0;
            vco_cal_result <= 7'h00;
        end else if (pll_drive.cal_start) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q == (slow ? 4'hC : 4'h1)) begin
                vco_cal_done <= 1'b1;
                vco_cal_result <= cal_value;
            end
        end else begin
            cnt_q <= 4'h0;
            vco_cal_done <= 1'b0;
            vco_cal_result <= ~vco_cal_result;
        end
    end
endmodule

/* tb/synth_channel_config_bench.sv */
// bench for the synthesizer block: apb tasks and lock sequences
// assumes pll_model on the analog side; plain-rate strap, then doubled
`timescale 1ns/10ps
module synth_channel_config_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic slow = 1'b0;
    logic ce = 1'b1;
    logic ref_dbl = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q;
    logic pready, pslverr, vco_cal_done, dig_tick, e;
    logic [6:0] cal_value = 7'h00;
    logic [6:0] vco_cal_result;
    synth_pkg::radio_state_t radio_state = synth_pkg::RADIO_OTHER;
    synth_pkg::pll_drive_t pll_drive;
    int err_total = 0, comparisons = 0, cyc = 0, cal_seen = 0;
    localparam logic [27:0] BW = 28'hABCDEF;

    always #5 pclk = ~pclk;

    synth_channel_config dut (.pclk(pclk), .presetn(presetn), .ce(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ref_doubled(ref_dbl), .radio_state(radio_state),
        .vco_cal_done(vco_cal_done), .vco_cal_result(vco_cal_result),
        .pll_drive(pll_drive), .dig_tick(dig_tick));
    pll_model pll (.pclk(pclk), .presetn(presetn), .pll_drive(pll_drive),
        .slow(slow), .cal_value(cal_value), .vco_cal_done(vco_cal_done),
        .vco_cal_result(vco_cal_result));

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string s, input logic [31:0] x, y);
        comparisons++;
        if (y !== x) begin
            err_total++;
            $display("MISMATCH %s exp %h got %h", s, x, y);
        end
    endtask

    // one apb transfer; holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // request a lock, then wait until calibration has ended
    task automatic lock(input synth_pkg::radio_state_t s);
        radio_state <= s;
        repeat (4) @(posedge pclk);
        while (pll_drive.cal_start !== 1'b0 ||
               pll_drive.synth_enable !== 1'b1) @(posedge pclk);
        repeat (3) @(posedge pclk);
    endtask

    function automatic logic [31:0] fw(logic [1:0] sh, logic [7:0] i, s);
        return ({4'h0, BW} << sh) + (32'({8'h00, i} * {8'h00, s}) << 8);
    endfunction

    // cycle ceiling well above the expected run; also counts cycles with cal_start high
    always @(posedge pclk) begin
        cyc++;
        if (pll_drive.cal_start === 1'b1) cal_seen++;
        if (cyc == 5000) begin
            err_total++;
            end_of_test();
        end
    end

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, synth_pkg::OFF_CTRL, 32'h0);
        chk("ctrl reset", 32'h0, q);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, e});
        $display("test reset done");
        apb(1'b1, synth_pkg::OFF_BASE, {4'h0, BW});
        apb(1'b1, synth_pkg::OFF_CTRL, 32'h24);
        apb(1'b1, synth_pkg::OFF_CHAN, 32'hFF);
        apb(1'b1, synth_pkg::OFF_SPACE, 32'h11);
        cal_value <= 7'h35;
        slow <= 1'b1;
        radio_state <= synth_pkg::RADIO_READY;
        repeat (3) @(posedge pclk);
        lock(synth_pkg::RADIO_TX);
        chk("freq tx", fw(2, 8'hFF, 8'h11), {1'b0, pll_drive.freq_word});
        chk("dividers", 32'h113, {22'h0, pll_drive[18:9]});
        chk("cal word", 32'h35, {25'h0, pll_drive.vco_cal_word});
        apb(1'b0, synth_pkg::OFF_CAL_TX, 32'h0);
        chk("cal tx reg", 32'h35, q);
        apb(1'b1, synth_pkg::OFF_CHAN, 32'h1);
        chk("freq held", fw(2, 8'hFF, 8'h11), {1'b0, pll_drive.freq_word});
        cal_value <= 7'h4C;
        slow <= 1'b0;
        lock(synth_pkg::RADIO_RX);
        chk("freq rx", fw(2, 8'h01, 8'h11), {1'b0, pll_drive.freq_word});
        apb(1'b0, synth_pkg::OFF_CAL_RX, 32'h0);
        chk("cal rx reg", 32'h4C, q);
        $display("test auto calibration done");
        radio_state <= synth_pkg::RADIO_READY;
        apb(1'b1, synth_pkg::OFF_CTRL, 32'h4F);
        apb(1'b1, synth_pkg::OFF_CAL_TX, 32'h12);
        cal_seen = 0;
        lock(synth_pkg::RADIO_TX);
        chk("no cal", 32'h0, cal_seen);
        chk("cal word", 32'h12, {25'h0, pll_drive.vco_cal_word});
        chk("dividers", 32'h226, {22'h0, pll_drive[18:9]});
        chk("freq div", fw(0, 8'h01, 8'h11), {1'b0, pll_drive.freq_word});
        $display("test no calibration done");
        // second reset: strap now says doubled reference
        presetn <= 1'b0;
        ref_dbl <= 1'b1;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        apb(1'b0, synth_pkg::OFF_STATUS, 32'h0);
        chk("status dbl", 32'h4, q);
        e = dig_tick;
        @(posedge pclk);
        chk("half tick", {31'h0, ~e}, {31'h0, dig_tick});
        ce <= 1'b0;
        @(posedge pclk);
        e = dig_tick;
        @(posedge pclk);
        chk("ce hold", {31'h0, e}, {31'h0, dig_tick});
        ce <= 1'b1;
        $display("test half rate done");
        end_of_test();
    end
endmodule
